// >>> smp_port.sv
`timescale 1ns/1ps
// Overview of operation
// - Four-wire full-duplex serial port, usable as master or as slave.
// - Detect another master starting a transfer while we do.
// - Bit rate at most clock/4 as slave, clock/8 as master.
// - Slave drives its data output MSB first; released when unselected.
// - Master-out data travels MSB first.
// - Master drives the serial clock; it times every data bit.
// - Slave select enables the slave; its active level is configurable.
// - As master, select is ignored unless fault detection is enabled.
// - Master operation follows the master-mode control bit.
// - Only the master starts a transfer; a slave never does.
// - A data buffer write in master mode starts a transfer at once.
// - Master shifts the character out MSB first while clocking.
// - Incoming master bits enter the shift register at its LSB.
// - At transfer end the received character is buffered and flagged.
// - Complete flag with interrupt enabled raises an interrupt request.
// - With the mode bit clear, the port is a slave on external clock.
// - Slave shifts out while receiving; received data replaces register.
// - Slave buffers received data and sets the complete flag too.
module smp_port
  import smp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Configuration
  input  wire logic       master_mode_select_in,
  input  wire logic       select_active_high_in,
  input  wire logic       fault_detect_en_in,
  input  wire logic       irq_en_in,
  input  wire logic       clear_complete_in,
  input  wire logic       clear_fault_in,
  // Status
  output logic            transfer_complete_flag_out,
  output logic            irq_out,
  output logic            collision_flag_out,
  output logic            mode_fault_flag_out,
  output logic            overrun_flag_out,
  output logic            busy_out,
  // Data buffer write
  input  wire logic [7:0] serial_data_buffer_in,
  input  wire logic       serial_data_buffer_valid_in,
  output logic            serial_data_buffer_ready_out,
  // Read buffer
  output logic [7:0]      read_data_out,
  output logic            read_valid_out,
  input  wire logic       read_ready_in,
  // Master pins
  output logic            master_out_pin_out,
  output logic            master_clock_out,
  input  wire logic       master_in_pin_in,
  // Slave pins
  input  wire logic       slave_clock_in,
  input  wire logic       slave_in_pin_in,
  input  wire logic       slave_select_in,
  output logic            slave_out_pin_out,
  output logic            slave_out_pin_oe_out
);

  logic [SMP_SYNC_W-1:0] pins_raw;
  logic [SMP_SYNC_W-1:0] sync1_ff;
  logic [SMP_SYNC_W-1:0] sync2_ff;
  logic                  sck_d_ff;
  smp_state_t            state_ff;
  smp_state_t            nxt_state;
  logic [7:0]            shift_ff;
  logic [7:0]            nxt_shift;
  logic [7:0]            tx_buf_ff;
  logic [3:0]            bit_cnt_ff;
  logic [3:0]            nxt_bit_cnt;
  logic [2:0]            half_cnt_ff;
  logic                  sample_ff;
  logic                  nxt_ready;
  logic                  mi_s;
  logic                  sck_s;
  logic                  si_s;
  logic                  ss_s;
  logic                  selected;
  logic                  slave_mode;
  logic                  master_on;
  logic                  accept;
  logic                  mst_start;
  logic                  half_done;
  logic                  shifting;
  logic                  mst_rise;
  logic                  mst_fall;
  logic                  slv_rise;
  logic                  slv_fall;
  logic                  slv_idle;
  logic                  fault_hit;
  logic                  col_set;
  logic                  mf_set;
  logic                  mst_done;
  logic                  slv_done;
  logic                  done;
  logic                  rise;
  logic                  fall;
  logic [7:0]            rx_word;
  logic                  fifo_in_ready;

  // four pins, either role
  // Every pin from the far party is synchronised before use.
  assign pins_raw = {slave_select_in, slave_in_pin_in, slave_clock_in,
                     master_in_pin_in};

  genvar gi;
  generate
    for (gi = 0; gi < SMP_SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          sync1_ff[gi] <= SMP_SYNC_RST[gi];
          sync2_ff[gi] <= SMP_SYNC_RST[gi];
        end
        else
        begin
          sync1_ff[gi] <= pins_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  assign mi_s  = sync2_ff[0];
  assign sck_s = sync2_ff[1];
  assign si_s  = sync2_ff[2];
  assign ss_s  = sync2_ff[3];

  assign selected   = (ss_s == select_active_high_in);
  assign slave_mode = ~master_mode_select_in;
  assign master_on  = master_mode_select_in & ~collision_flag_out &
                      ~mode_fault_flag_out;

  assign slv_rise  = slave_mode & selected & sck_s & ~sck_d_ff;
  assign slv_fall  = slave_mode & selected & ~sck_s & sck_d_ff;
  assign slv_idle  = slave_mode & ~selected;

  assign accept    = serial_data_buffer_valid_in &
                     serial_data_buffer_ready_out;
  assign mst_start = accept & master_on;

  assign shifting  = (state_ff == SMP_SHIFT);
  assign half_done = (half_cnt_ff == SMP_HALF_ZERO);
  assign mst_rise  = shifting & half_done & ~master_clock_out;
  assign mst_fall  = shifting & half_done & master_clock_out;

  // select watched in master mode only when enabled
  assign fault_hit = master_mode_select_in & fault_detect_en_in & selected;
  assign col_set   = fault_hit & shifting;
  assign mf_set    = fault_hit & ~shifting;

  assign mst_done  = mst_fall & (bit_cnt_ff == SMP_CNT_FULL) & ~col_set;
  assign slv_done  = slv_rise & (bit_cnt_ff == SMP_CNT_LAST);
  assign done      = mst_done | slv_done;
  assign rise      = mst_rise | slv_rise;
  assign fall      = (mst_fall & (bit_cnt_ff != SMP_CNT_FULL)) |
                     (slv_fall & (bit_cnt_ff != SMP_CNT_ZERO));

  // new bit enters at the LSB
  assign rx_word   = slave_mode ? {shift_ff[6:0], si_s}
                                : {shift_ff[6:0], sample_ff};

  always_comb
  begin
    nxt_shift = shift_ff;
    if (mst_start)
    begin
      nxt_shift = serial_data_buffer_in;
    end
    else if (slv_idle)
    begin
      nxt_shift = tx_buf_ff;
    end
    else if (done)
    begin
      nxt_shift = rx_word;
    end
    else if (fall)
    begin
      nxt_shift = {shift_ff[6:0], sample_ff};
    end
  end

  always_comb
  begin
    nxt_bit_cnt = bit_cnt_ff;
    if (mst_start | slv_idle | done | col_set)
    begin
      nxt_bit_cnt = SMP_CNT_ZERO;
    end
    else if (rise)
    begin
      nxt_bit_cnt = bit_cnt_ff + 4'h1;
    end
  end

  // only a master-mode write leaves idle
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SMP_IDLE:
      begin
        if (mst_start)
        begin
          nxt_state = SMP_SHIFT;
        end
      end
      SMP_SHIFT:
      begin
        if (~master_on | col_set | mst_done)
        begin
          nxt_state = SMP_IDLE;
        end
      end
      default:
      begin
        nxt_state = SMP_IDLE;
      end
    endcase
  end

  // Ready drops for the finishing cycle so the fifo room is re-checked.
  assign nxt_ready = master_mode_select_in ?
                     (master_on & (nxt_state == SMP_IDLE) & fifo_in_ready &
                      ~mst_start & ~done & ~fault_hit) : 1'b1;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_ff    <= SMP_IDLE;
      shift_ff    <= SMP_CHAR_RST;
      bit_cnt_ff  <= SMP_CNT_ZERO;
      sample_ff   <= 1'b0;
      sck_d_ff    <= 1'b0;
      tx_buf_ff   <= SMP_CHAR_RST;
    end
    else
    begin
      state_ff   <= nxt_state;
      shift_ff   <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
      sck_d_ff   <= sck_s;
      if (rise)
      begin
        sample_ff <= master_mode_select_in ? mi_s : si_s;
      end
      if (accept & slave_mode)
      begin
        tx_buf_ff <= serial_data_buffer_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      half_cnt_ff      <= SMP_HALF_LOAD;
      master_clock_out <= 1'b0;
    end
    else if (nxt_state != SMP_SHIFT)
    begin
      half_cnt_ff      <= SMP_HALF_LOAD;
      master_clock_out <= 1'b0;
    end
    else if (half_done)
    begin
      half_cnt_ff      <= SMP_HALF_LOAD;
      master_clock_out <= ~master_clock_out;
    end
    else
    begin
      half_cnt_ff <= half_cnt_ff - 3'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      master_out_pin_out   <= 1'b0;
      slave_out_pin_out    <= 1'b0;
      slave_out_pin_oe_out <= 1'b0;
      busy_out             <= 1'b0;
    end
    else
    begin
      master_out_pin_out   <= master_mode_select_in & nxt_shift[7];
      slave_out_pin_out    <= nxt_shift[7];
      slave_out_pin_oe_out <= slave_mode & selected;
      busy_out             <= (nxt_state == SMP_SHIFT);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      transfer_complete_flag_out   <= 1'b0;
      collision_flag_out           <= 1'b0;
      mode_fault_flag_out          <= 1'b0;
      overrun_flag_out             <= 1'b0;
      irq_out                      <= 1'b0;
      serial_data_buffer_ready_out <= 1'b0;
    end
    else
    begin
      transfer_complete_flag_out <= done |
        (transfer_complete_flag_out & ~clear_complete_in);
      collision_flag_out  <= col_set |
        (collision_flag_out & ~clear_fault_in);
      mode_fault_flag_out <= mf_set |
        (mode_fault_flag_out & ~clear_fault_in);
      // A slave cannot stall the far master, so a full buffer loses data.
      overrun_flag_out    <= (done & ~fifo_in_ready) |
        (overrun_flag_out & ~clear_complete_in);
      irq_out <= transfer_complete_flag_out & irq_en_in;
      serial_data_buffer_ready_out <= nxt_ready;
    end
  end

  // received word into the read buffer
  smp_fifo #(
    .WIDTH (SMP_CHAR_W),
    .DEPTH (SMP_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .in_data_in    (rx_word),
    .in_valid_in   (done),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (read_data_out),
    .out_valid_out (read_valid_out),
    .out_ready_in  (read_ready_in)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_start;
    mst_start;
  endsequence

  sequence s_run;
    busy_out ##0 master_out_pin_out == $past(serial_data_buffer_in[7]);
  endsequence

  a_start_on_write: assert property (s_start |=> s_run)
    else $error("Master write did not start a transfer MSB first.");

  // An aborted transfer may cut the high phase short, so only falls
  // that end a normal half period are measured.
  a_master_half_rate: assert property (
    $fell(master_clock_out) && master_mode_select_in &&
    !collision_flag_out && !mode_fault_flag_out
    |-> $past(master_clock_out, 4))
    else $error("Master serial clock high phase too short.");

  a_clock_idle_low: assert property (!busy_out |-> !master_clock_out)
    else $error("Serial clock moves while idle.");

  a_slave_never_starts: assert property (slave_mode |=> !busy_out)
    else $error("Slave began a master transfer.");

  a_done_sets_flag: assert property (
    done |=> transfer_complete_flag_out)
    else $error("Completion flag not set at end of transfer.");

  a_flag_sticky: assert property (
    transfer_complete_flag_out && !clear_complete_in
    |=> transfer_complete_flag_out)
    else $error("Completion flag dropped without a clear.");

  a_irq_request: assert property (
    transfer_complete_flag_out && irq_en_in |=> irq_out)
    else $error("Interrupt not raised for completion.");

  a_fault_stops: assert property (
    fault_hit |=> !busy_out ##0
    (collision_flag_out || mode_fault_flag_out))
    else $error("Fault did not stop master operation.");

  a_slave_release: assert property (
    slave_mode && !selected |=> !slave_out_pin_oe_out)
    else $error("Slave drives output while not selected.");

endmodule : smp_port

// >>> smp_pkg.sv
package smp_pkg;

  // Character and buffer shape.
  localparam int unsigned SMP_CHAR_W     = 8;
  localparam int unsigned SMP_FIFO_DEPTH = 16;
  localparam int unsigned SMP_SYNC_W     = 4;

  // System clock period and the master serial clock half period.
  localparam int unsigned SMP_CLK_NS     = 40;
  localparam int unsigned SMP_HALF_NS    = 160;
  localparam int unsigned SMP_HALF_CYC   =
    (SMP_HALF_NS + SMP_CLK_NS - 1) / SMP_CLK_NS;
  localparam logic [2:0]  SMP_HALF_LOAD  = 3'(SMP_HALF_CYC - 1);
  localparam logic [2:0]  SMP_HALF_ZERO  = 3'h0;

  // Bit counter values.
  localparam logic [3:0]  SMP_CNT_ZERO   = 4'h0;
  localparam logic [3:0]  SMP_CNT_LAST   = 4'h7;
  localparam logic [3:0]  SMP_CNT_FULL   = 4'h8;

  // Values after reset.
  localparam logic [7:0]  SMP_CHAR_RST   = 8'h00;
  localparam logic [3:0]  SMP_SYNC_RST   = 4'h0;

  // Master sequencer states.
  typedef enum logic [0:0] {
    SMP_IDLE  = 1'b0,
    SMP_SHIFT = 1'b1
  } smp_state_t;

endpackage : smp_pkg

// >>> smp_fifo.sv
`timescale 1ns/1ps
module smp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  // Filling side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // Draining side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;
  logic             stage_free;

  // The output stage is a register so the drain side sees flop outputs.
  assign in_ready_out = (count_ff != FULL_CNT);
  assign push         = in_valid_in & in_ready_out;
  assign stage_free   = ~out_valid_out | out_ready_in;
  assign pop          = stage_free & (count_ff != '0);

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr_ff     <= '0;
      rd_ptr_ff     <= '0;
      count_ff      <= '0;
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff    <= rd_ptr_ff + 1'b1;
        out_data_out <= mem_ff[rd_ptr_ff];
      end
      if (stage_free)
      begin
        out_valid_out <= pop;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : smp_fifo

// >>> smp_peer.sv
`timescale 1ns/1ps
module smp_peer (
  // Far side while the device is master
  input  wire logic m_clk_in,
  input  wire logic m_mosi_in,
  output logic      m_miso_out,
  // Far side while the device is slave
  output logic      s_clk_out,
  output logic      s_mosi_out,
  output logic      s_sel_out,
  input  wire logic s_miso_in,
  input  wire logic s_oe_in,
  input  wire logic sel_high_in
);
  logic [7:0] reply_ff = 8'h00;
  logic [7:0] got_ff   = 8'h00;
  logic       sel_on   = 1'b0;
  wire        s_line;

  assign s_line = s_oe_in ? s_miso_in : 1'b1;
  assign s_sel_out = sel_on ~^ sel_high_in;

  initial
  begin
    m_miso_out = 1'b0;
    s_clk_out  = 1'b0;
    s_mosi_out = 1'b0;
  end

  // reply bits move after the falling clock
  always @(negedge m_clk_in)
  begin
    reply_ff   = {reply_ff[6:0], ~reply_ff[0]};
    m_miso_out = reply_ff[7];
  end

  always @(posedge m_clk_in)
    got_ff = {got_ff[6:0], m_mosi_in};

  task automatic load(input logic [7:0] v);
    reply_ff   = v;
    m_miso_out = v[7];
  endtask : load

  // one character clocked at 320 ns
  task automatic frame(input logic [7:0] d, output logic [7:0] q);
    #7 sel_on = 1'b1;
    #400;
    for (int i = 7; i >= 0; i--)
    begin
      s_mosi_out = d[i];
      #160 s_clk_out = 1'b1;
      q[i] = s_line;
      #160 s_clk_out = 1'b0;
    end
    #400 sel_on = 1'b0;
    // A released line must not keep showing the last bit.
    s_mosi_out = ~s_mosi_out;
    #400;
  endtask : frame
endmodule : smp_peer

// >>> spi_master_slave_port_tb.sv
`timescale 1ns/1ps
module spi_master_slave_port_tb;
  import smp_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic       mode = 1'b1, sel_high = 1'b1, fault_en = 1'b0;
  logic       irq_en = 1'b0, clr_cpl = 1'b0, clr_flt = 1'b0;
  logic       wr_valid = 1'b0, rd_ready = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic       cpl, irq, coll, mfault, ovr, busy, wr_ready, rd_valid;
  logic       mosi, sck, miso, s_clk, s_mosi, s_sel, s_miso, s_oe;
  logic [7:0] rd_data, d, r, q;
  logic [31:0] seed = 32'h58C9;
  logic [7:0] exp_q[$];
  int         fails = 0;
  int         samples_checked = 0;

  always #20 clk_in = ~clk_in;

  smp_port i_smp_port (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .master_mode_select_in(mode), .select_active_high_in(sel_high),
    .fault_detect_en_in(fault_en), .irq_en_in(irq_en),
    .clear_complete_in(clr_cpl), .clear_fault_in(clr_flt),
    .transfer_complete_flag_out(cpl), .irq_out(irq),
    .collision_flag_out(coll), .mode_fault_flag_out(mfault),
    .overrun_flag_out(ovr), .busy_out(busy),
    .serial_data_buffer_in(wr_data),
    .serial_data_buffer_valid_in(wr_valid),
    .serial_data_buffer_ready_out(wr_ready),
    .read_data_out(rd_data), .read_valid_out(rd_valid),
    .read_ready_in(rd_ready), .master_out_pin_out(mosi),
    .master_clock_out(sck), .master_in_pin_in(miso),
    .slave_clock_in(s_clk), .slave_in_pin_in(s_mosi),
    .slave_select_in(s_sel), .slave_out_pin_out(s_miso),
    .slave_out_pin_oe_out(s_oe));

  smp_peer i_smp_peer (.m_clk_in(sck), .m_mosi_in(mosi), .m_miso_out(miso),
    .s_clk_out(s_clk), .s_mosi_out(s_mosi), .s_sel_out(s_sel),
    .s_miso_in(s_miso), .s_oe_in(s_oe), .sel_high_in(sel_high));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic put(input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_in);
    wr_data  <= v;
    wr_valid <= 1'b1;
    do @(negedge clk_in); while (wr_ready !== 1'b1 && ++n < 200);
    if (n >= 200) fails++;
    @(posedge clk_in);
    wr_valid <= 1'b0;
  endtask : put

  task automatic pop(input logic [7:0] e);
    int n;
    n = 0;
    do @(negedge clk_in); while (rd_valid !== 1'b1 && ++n < 50);
    check("read_valid", {7'h0, rd_valid}, 8'h01);
    check("read_data", rd_data, e);
    @(posedge clk_in);
    rd_ready <= 1'b1;
    @(posedge clk_in);
    rd_ready <= 1'b0;
  endtask : pop

  task automatic wait_flag();
    int n;
    n = 0;
    do @(negedge clk_in); while (cpl !== 1'b1 && ++n < 400);
    if (n >= 400) fails++;
  endtask : wait_flag

  task automatic pulse(input bit fault);
    @(posedge clk_in);
    if (fault) clr_flt <= 1'b1;
    else clr_cpl <= 1'b1;
    @(posedge clk_in);
    clr_flt <= 1'b0;
    clr_cpl <= 1'b0;
    repeat (2) @(negedge clk_in);
  endtask : pulse

  task automatic end_of_test();
    $display("samples_checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  initial
  begin
    #400_000;
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    // Select stays active: with fault detection off it must not matter.
    i_smp_peer.sel_on = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      d = rnd();
      r = rnd();
      @(posedge clk_in);
      irq_en <= k[0];
      i_smp_peer.load(r);
      put(d);
      wait_flag();
      check("mosi_char", i_smp_peer.got_ff, d);
      check("busy", {7'h0, busy}, 8'h00);
      @(negedge clk_in);
      check("irq", {7'h0, irq}, {7'h0, k[0]});
      pop(r);
      check("complete", {7'h0, cpl}, 8'h01);
      pulse(1'b0);
      check("complete", {7'h0, cpl}, 8'h00);
    end
    i_smp_peer.sel_on = 1'b0;
    // Let the released select pass the synchroniser before watching it.
    repeat (3) @(posedge clk_in);
    fault_en <= 1'b1;
    i_smp_peer.load(8'hA5);
    put(rnd());
    repeat (20) @(posedge clk_in);
    i_smp_peer.sel_on = 1'b1;
    repeat (10) @(negedge clk_in);
    check("collision", {7'h0, coll}, 8'h01);
    check("busy", {7'h0, busy}, 8'h00);
    check("complete", {7'h0, cpl}, 8'h00);
    pulse(1'b1);
    repeat (6) @(negedge clk_in);
    check("mode_fault", {7'h0, mfault}, 8'h01);
    check("ready", {7'h0, wr_ready}, 8'h00);
    i_smp_peer.sel_on = 1'b0;
    repeat (6) @(negedge clk_in);
    pulse(1'b1);
    check("faults", {6'h0, coll, mfault}, 8'h00);
    @(posedge clk_in);
    mode <= 1'b0;
    fault_en <= 1'b0;
    // Read side stalls so the receive buffer fills until it overflows.
    for (int k = 0; k < 18; k++)
    begin
      if (k == 9)
      begin
        @(posedge clk_in);
        sel_high <= 1'b0;
      end
      d = rnd();
      r = rnd();
      put(d);
      i_smp_peer.frame(r, q);
      check("slave_out", q, d);
      if (exp_q.size() < 17) exp_q.push_back(r);
      repeat (8) @(negedge clk_in);
      check("overrun", {7'h0, ovr}, {7'h0, k >= 17});
      check("released", {7'h0, s_oe}, 8'h00);
      check("complete", {7'h0, cpl}, 8'h01);
    end
    while (exp_q.size() > 0)
      pop(exp_q.pop_front());
    pulse(1'b0);
    check("overrun", {7'h0, ovr}, 8'h00);
    end_of_test();
  end
endmodule : spi_master_slave_port_tb
